// file: dv/d2mr_ctrl_model.sv
module d2mr_ctrl_model
  import d2mr_pkg::*;
(
  input wire logic link_clk_in,
  output logic cke_out,
  output d2mr_cmd_t cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cke_out = 1'b0;
    cmd_out = {4'hf, 2'h0, 14'h0000};
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  task automatic drive(input logic [3:0] strb, input logic [1:0] ba,
                       input logic [13:0] a);
    @(posedge link_clk_in);
    #1;
    cmd_out = {strb, ba, a};
  endtask

  // deselected: stale lines flip so a decode of them cannot look valid
  task automatic nop();
    @(posedge link_clk_in);
    #1;
    cmd_out = {1'b1, ~cmd_out[18:0]};
  endtask

  task automatic wake();
    @(posedge link_clk_in);
    #1;
    cke_out = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  // write recovery rounded up to whole cycles, stored as code
  function automatic logic [2:0] wr_code(input int twr_ps, input int tck_ps);
    return 3'((twr_ps + tck_ps - 1) / tck_ps - 1);
  endfunction

  task automatic mrs(input logic [1:0] ba, input logic [13:0] w);
    repeat (4) nop();
    drive(4'h0, ba, w & 14'h3f7f);
    nop();
    nop();
  endtask

  // no terminate pattern is ever sent, bursts only end or restart
  task automatic col(input logic wr, input logic [COL_W-1:0] c);
    drive({3'b010, ~wr}, 2'h2, {4'h0, c});
  endtask
endmodule

// file: dv/d2mr_mode_burst_bench.sv
module d2mr_mode_burst_bench
  import d2mr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cke;
  d2mr_cmd_t cmd;
  d2mr_mode_t mode;
  logic [3:0] exit_cyc;
  logic dll_pls, bv, bw;
  logic [COL_W-1:0] ce, co;
  logic [20:0] exp_q[$];
  logic [13:0] cur = MODE_RST;
  logic wr;
  int bad_count = 0;
  int tests_run = 0;
  int dll_seen = 0;
  int dll_exp = 0;
  int cyc = 0;
  int tck[5] = '{7500, 5000, 3750, 3000, 2500};

  always #2 clk_in = ~clk_in;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  d2mr_mode_burst d2mr_mode_burst_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .link_clk_in(link_clk), .cke_in(cke),
    .link_cmd_in(cmd), .mode_out(mode), .exit_cycles_out(exit_cyc),
    .dll_reset_out(dll_pls), .burst_valid_out(bv),
    .burst_write_out(bw), .col_even_out(ce), .col_odd_out(co));
  d2mr_ctrl_model ctrl_inst (.link_clk_in(link_clk), .cke_out(cke),
    .cmd_out(cmd));

  // ----------------------------------------------------------------
  // expectations and compares
  // ----------------------------------------------------------------
  function automatic d2mr_mode_t exp_mode(input logic [13:0] w);
    d2mr_mode_t m;
    m.pd_slow = w[F_PD];
    m.wr_cycles = w[11:9] + 3'h1;
    m.test_mode = w[F_TM];
    m.dll_reset = w[F_DLL];
    m.cas_lat = w[6:4];
    m.interleave = w[F_BT];
    m.beats8 = (w[2:0] == BL_CODE8);
    m.reserved = w[F_TM] | !(w[2:0] inside {BL_CODE4, BL_CODE8})
      | (w[6:4] < CL_MIN_CODE) | (w[6:4] > CL_MAX_CODE)
      | (w[11:9] < WR_MIN_CODE) | (w[11:9] > WR_MAX_CODE);
    return m;
  endfunction

  function automatic logic [COL_W-1:0] colx(input logic [COL_W-1:0] s,
    input logic [2:0] k, input logic it, input logic b8);
    logic [2:0] lo;
    if (it) lo = s[2:0] ^ (b8 ? k : {1'b0, k[1:0]});
    else lo = {s[2] ^ (b8 & k[2]), s[1:0] + k[1:0]};
    return {s[COL_W-1:3], lo};
  endfunction

  task automatic chk_val(input string n, input int e, input int g);
    tests_run++;
    if (g != e) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic chk_mode(input d2mr_mode_t e, input logic [3:0] ex);
    tests_run += 2;
    if (mode !== e || exit_cyc !== ex) begin
      bad_count++;
      $display("[FAIL] mode expected %h/%h seen %h/%h", e, ex, mode,
               exit_cyc);
    end
  endtask

  task automatic chk_pair(input logic [20:0] e, input logic [20:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] burst expected %h seen %h", e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------------
  task automatic load(input logic [1:0] ba, input logic [13:0] w);
    ctrl_inst.mrs(ba, w);
    if (ba == 2'h0) begin
      cur = w & 14'h3f7f;
      if (w[F_DLL]) dll_exp++;
    end
    repeat (4) @(posedge link_clk);
    #1;
    chk_mode(exp_mode(cur),
             cur[F_PD] ? SLOW_EXIT_CYC : FAST_EXIT_CYC);
  endtask

  // np pairs come out before the next command restarts the order
  task automatic burst(input logic w, input logic [COL_W-1:0] s, int np);
    logic b8;
    b8 = (cur[2:0] == BL_CODE8);
    for (int k = 0; k < np; k++) begin
      exp_q.push_back({w, colx(s, 3'(2 * k), cur[F_BT], b8),
                       colx(s, 3'(2 * k + 1), cur[F_BT], b8)});
    end
    ctrl_inst.col(w, s);
    repeat (np - 1) ctrl_inst.nop();
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchers
  // ----------------------------------------------------------------
  always @(posedge link_clk) begin
    if (bv === 1'b1) begin
      if (exp_q.size() == 0) chk_pair(21'h0, {bw, ce, co});
      else chk_pair(exp_q.pop_front(), {bw, ce, co});
    end
  end

  always @(posedge clk_in) begin
    if (dll_pls === 1'b1) dll_seen++;
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(10626));
    repeat (2) @(posedge link_clk);
    #1;
    sys_rst_in = 1'b0;
    chk_mode(exp_mode(MODE_RST), FAST_EXIT_CYC);
    // clock enable still low: the load must be ignored
    ctrl_inst.mrs(2'h0, 14'h1373);
    repeat (4) @(posedge link_clk);
    #1;
    chk_mode(exp_mode(MODE_RST), FAST_EXIT_CYC);
    ctrl_inst.wake();
    foreach (tck[i]) begin
      load(2'h0, {1'b0, 1'($urandom_range(1)),
        ctrl_inst.wr_code(15000, tck[i]), 1'($urandom_range(1)), 1'b0,
        3'(CL_MIN_CODE + $urandom_range(3)), 1'($urandom_range(1)),
        $urandom_range(1) ? BL_CODE8 : BL_CODE4});
    end
    load(2'h1, 14'h1fff);
    load(2'h0, 14'h0372);
    load(2'h0, 14'h2c31);
    chk_val("dll pulses", dll_exp, dll_seen);
    // mid-run reset brings back the reset image
    @(posedge link_clk);
    #1;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge link_clk);
    #1;
    sys_rst_in = 1'b0;
    cur = MODE_RST;
    chk_mode(exp_mode(MODE_RST), FAST_EXIT_CYC);
    for (int m = 0; m < 4; m++) begin
      load(2'h0, {1'b0, m[1], 8'h23, m[1], m[0] ? BL_CODE8 : BL_CODE4});
      wr = 1'($urandom_range(1));
      repeat (6) burst(wr, COL_W'($urandom_range(1023)), m[0] ? 4 : 2);
    end
    burst(1'b0, COL_W'($urandom_range(1023)), 2);
    burst(1'b0, COL_W'($urandom_range(1023)), 4);
    repeat (8) ctrl_inst.nop();
    chk_val("pending beats", 0, exp_q.size());
    wrap_up();
  end
endmodule

// file: hdl/d2mr_mode_burst.sv
// Functional notes
// - mode load: all strobes and banks low
// - bit twelve picks fast or slow exit
// - bits eleven-nine give recovery two to six
// - bit eight pulses a loop reset
// - bits six-four give latency three to six
// - bit three: sequential or interleaved order
// - code 010 selects four beats
// - top address bit only on x8
// - four-beat order from two start bits
// - eight-beat sequential rotates within nibble
// - eight-beat interleave: start xor beat
// - back-to-back bursts with no gap
module d2mr_mode_burst
  import d2mr_pkg::*;
#(
  parameter bit WIDE16 = 1'b0
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic cke_in,
  input wire d2mr_cmd_t link_cmd_in,
  output d2mr_mode_t mode_out,
  output logic [3:0] exit_cycles_out,
  output logic dll_reset_out,
  output logic burst_valid_out,
  output logic burst_write_out,
  output logic [COL_W-1:0] col_even_out,
  output logic [COL_W-1:0] col_odd_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] burst_col(input logic [2:0] start,
                                           input logic [2:0] beat,
                                           input logic inter,
                                           input logic b8);
    logic [2:0] c;
    c = '0;
    if (inter) begin
      c = start ^ {beat[2] & b8, beat[1:0]};
    end else begin
      c[1:0] = start[1:0] + beat[1:0];
      c[2] = start[2] ^ (beat[2] & b8);
    end
    return c;
  endfunction

  function automatic d2mr_mode_t decode(input logic [13:0] w);
    d2mr_mode_t m;
    logic [2:0] wr, cl, bl;
    wr = w[F_WR_LO +: 3];
    cl = w[F_CL_LO +: 3];
    bl = w[F_BL_LO +: 3];
    m.pd_slow = w[F_PD];
    m.wr_cycles = wr + 3'h1;
    m.test_mode = w[F_TM];
    m.dll_reset = w[F_DLL];
    m.cas_lat = cl;
    m.interleave = w[F_BT];
    m.beats8 = (bl == BL_CODE8);
    m.reserved = (wr < WR_MIN_CODE) || (wr > WR_MAX_CODE) ||
                 (cl < CL_MIN_CODE) || (cl > CL_MAX_CODE) ||
                 w[F_TM] || ((bl != BL_CODE4) && (bl != BL_CODE8));
    return m;
  endfunction

  // ----------------------------------------------------------------
  // link side: command decode
  // ----------------------------------------------------------------
  logic sel, mrs_hit, col_hit;
  logic [13:0] addr_m;

  always_comb begin
    sel = cke_in && !link_cmd_in.cs_n;
    mrs_hit = sel && !link_cmd_in.ras_n && !link_cmd_in.cas_n &&
              !link_cmd_in.we_n && (link_cmd_in.ba == 2'h0);
    // burst terminate pattern decodes to nothing here
    col_hit = sel && link_cmd_in.ras_n && !link_cmd_in.cas_n;
    addr_m = link_cmd_in.addr & (WIDE16 ? MASK_X16 : MASK_X8);
  end

  // ----------------------------------------------------------------
  // link side: mode word and burst sequencer
  // ----------------------------------------------------------------
  logic [13:0] mode_reg, mode_next;
  logic [COL_W-1:0] start_reg, start_next;
  logic [1:0] pair_reg, pair_next;
  logic active_reg, active_next;
  logic wr_reg, wr_next;
  logic valid_reg, valid_next;
  logic bw_reg, bw_next;
  logic [COL_W-1:0] ce_reg, ce_next, co_reg, co_next;
  logic b8, inter;

  always_comb begin
    b8 = (mode_reg[F_BL_LO +: 3] == BL_CODE8);
    inter = mode_reg[F_BT];
    mode_next = mrs_hit ? addr_m : mode_reg;
    start_next = start_reg;
    pair_next = pair_reg;
    active_next = active_reg;
    wr_next = wr_reg;
    // a new column command restarts at once: seamless chaining and
    // eight-beat cut-short look the same from here
    if (col_hit) begin
      start_next = link_cmd_in.addr[COL_W-1:0];
      pair_next = 2'h0;
      active_next = 1'b1;
      wr_next = !link_cmd_in.we_n;
    end else if (active_reg) begin
      if (pair_reg == (b8 ? PAIR_LAST8 : PAIR_LAST4)) begin
        active_next = 1'b0;
      end else begin
        pair_next = pair_reg + 2'h1;
      end
    end
    valid_next = active_reg;
    bw_next = active_reg && wr_reg;
    ce_next = {start_reg[COL_W-1:3],
               burst_col(start_reg[2:0], {pair_reg, 1'b0}, inter, b8)};
    co_next = {start_reg[COL_W-1:3],
               burst_col(start_reg[2:0], {pair_reg, 1'b1}, inter, b8)};
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_reg <= MODE_RST;
      start_reg <= '0;
      pair_reg <= 2'h0;
      active_reg <= 1'b0;
      wr_reg <= 1'b0;
      valid_reg <= 1'b0;
      bw_reg <= 1'b0;
      ce_reg <= '0;
      co_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      start_reg <= start_next;
      pair_reg <= pair_next;
      active_reg <= active_next;
      wr_reg <= wr_next;
      valid_reg <= valid_next;
      bw_reg <= bw_next;
      ce_reg <= ce_next;
      co_reg <= co_next;
    end
  end

  // ----------------------------------------------------------------
  // crossing to the system clock
  // ----------------------------------------------------------------
  logic [13:0] xword;
  logic xpulse;

  d2mr_word_sync #(.W(MODE_W)) u_sync (
    .src_clk_in(link_clk_in),
    .dst_clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .src_load_in(mrs_hit),
    .src_word_in(addr_m),
    .dst_word_out(xword),
    .dst_pulse_out(xpulse)
  );

  // ----------------------------------------------------------------
  // system side: decoded fields
  // ----------------------------------------------------------------
  // reset image decoded once so the reset branch loads a constant
  localparam d2mr_mode_t DM_RST = decode(MODE_RST);
  d2mr_mode_t dm_reg, dm_next;
  logic [3:0] exit_reg, exit_next;
  logic dll_reg, dll_next;

  always_comb begin
    dm_next = xpulse ? decode(xword) : dm_reg;
    exit_next = dm_next.pd_slow ? SLOW_EXIT_CYC : FAST_EXIT_CYC;
    dll_next = xpulse && xword[F_DLL];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dm_reg <= DM_RST;
      exit_reg <= FAST_EXIT_CYC;
      dll_reg <= 1'b0;
    end else begin
      dm_reg <= dm_next;
      exit_reg <= exit_next;
      dll_reg <= dll_next;
    end
  end

  assign mode_out = dm_reg;
  assign exit_cycles_out = exit_reg;
  assign dll_reset_out = dll_reg;
  assign burst_valid_out = valid_reg;
  assign burst_write_out = bw_reg;
  assign col_even_out = ce_reg;
  assign col_odd_out = co_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mode_load_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) mrs_hit |=> mode_reg == $past(addr_m))
    else $error("mode word not loaded");
  mode_hold_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) !mrs_hit |=> $stable(mode_reg))
    else $error("mode word changed without load");
  top_bit_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) mrs_hit |=> mode_reg[MODE_W-1] ==
    (!WIDE16 && $past(link_cmd_in.addr[MODE_W-1])))
    else $error("top mode bit not handled per width");
  first_col_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) col_hit |-> ##2 (burst_valid_out &&
    col_even_out == $past(link_cmd_in.addr[COL_W-1:0], 2)))
    else $error("burst does not start at given column");
  len_four_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) (col_hit && !b8) ##1 (!col_hit)[*2]
    |-> burst_valid_out ##2 !burst_valid_out)
    else $error("four-beat burst length wrong");
  len_eight_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) (col_hit && b8) ##1 (!col_hit)[*4]
    |-> burst_valid_out ##2 !burst_valid_out)
    else $error("eight-beat burst length wrong");
  seq_pair_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) burst_valid_out && !inter |->
    col_odd_out[1:0] == col_even_out[1:0] + 2'h1 &&
    col_odd_out[2] == col_even_out[2])
    else $error("sequential pair order wrong");
  ilv_pair_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) burst_valid_out && inter |->
    (col_odd_out[2:0] ^ col_even_out[2:0]) == 3'h1)
    else $error("interleaved pair order wrong");
  no_gap_a: assert property (@(posedge link_clk_in)
    disable iff (sys_rst_in) burst_valid_out && col_hit |->
    ##1 burst_valid_out ##1 burst_valid_out)
    else $error("gap between chained bursts");
  dll_pulse_a: assert property (@(posedge clk_in)
    disable iff (sys_rst_in) dll_reset_out |=> !dll_reset_out)
    else $error("loop reset longer than one cycle");
  exit_sel_a: assert property (@(posedge clk_in)
    disable iff (sys_rst_in) exit_cycles_out ==
    (mode_out.pd_slow ? SLOW_EXIT_CYC : FAST_EXIT_CYC))
    else $error("exit delay does not match select");
  cas_range_a: assert property (@(posedge clk_in)
    disable iff (sys_rst_in) !mode_out.reserved |->
    mode_out.cas_lat >= CL_MIN_CODE && mode_out.cas_lat <= CL_MAX_CODE)
    else $error("latency out of range not flagged");

endmodule

// file: hdl/d2mr_pkg.sv
package d2mr_pkg;

  // ----------------------------------------------------------------
  // operating mode word layout
  // ----------------------------------------------------------------
  localparam int MODE_W = 14;
  localparam int COL_W = 10;
  localparam int F_BL_LO = 0;
  localparam int F_BT = 3;
  localparam int F_CL_LO = 4;
  localparam int F_TM = 7;
  localparam int F_DLL = 8;
  localparam int F_WR_LO = 9;
  localparam int F_PD = 12;
  localparam logic [13:0] MASK_X8 = 14'h3fff;
  localparam logic [13:0] MASK_X16 = 14'h1fff;
  // reset image: four beats, sequential, latency 3, recovery 2
  localparam logic [13:0] MODE_RST = 14'h0232;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [2:0] CL_MIN_CODE = 3'h3;
  localparam logic [2:0] CL_MAX_CODE = 3'h6;
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  localparam logic [2:0] WR_MAX_CODE = 3'h5;
  localparam logic [1:0] PAIR_LAST4 = 2'h1;
  localparam logic [1:0] PAIR_LAST8 = 2'h3;

  // ----------------------------------------------------------------
  // power-down exit delays, in link clock cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] FAST_EXIT_CYC = 4'h2;
  localparam logic [3:0] SLOW_EXIT_CYC = 4'h6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [13:0] addr;
  } d2mr_cmd_t;

  typedef struct packed {
    logic pd_slow;
    logic [2:0] wr_cycles;
    logic test_mode;
    logic dll_reset;
    logic [2:0] cas_lat;
    logic interleave;
    logic beats8;
    logic reserved;
  } d2mr_mode_t;

endpackage

// file: hdl/d2mr_word_sync.sv
module d2mr_word_sync
  import d2mr_pkg::*;
#(
  parameter int W = 14
) (
  input wire logic src_clk_in,
  input wire logic dst_clk_in,
  input wire logic sys_rst_in,
  input wire logic src_load_in,
  input wire logic [W-1:0] src_word_in,
  output logic [W-1:0] dst_word_out,
  output logic dst_pulse_out
);

  // ----------------------------------------------------------------
  // source side: hold word, flip toggle
  // ----------------------------------------------------------------
  logic [W-1:0] hold_reg, hold_next;
  logic tog_reg, tog_next;

  always_comb begin
    hold_next = src_load_in ? src_word_in : hold_reg;
    tog_next = tog_reg ^ src_load_in;
  end

  always_ff @(posedge src_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold_reg <= '0;
      tog_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      tog_reg <= tog_next;
    end
  end

  // ----------------------------------------------------------------
  // destination side
  // ----------------------------------------------------------------
  // hold word is stable long before the toggle lands, so it is
  // sampled without its own synchroniser
  logic s1_reg, s2_reg, s3_reg;
  logic s1_next, s2_next, s3_next;
  logic [W-1:0] word_reg, word_next;
  logic pulse_reg, pulse_next;

  always_comb begin
    s1_next = tog_reg;
    s2_next = s1_reg;
    s3_next = s2_reg;
    pulse_next = s2_reg ^ s3_reg;
    word_next = (s2_reg ^ s3_reg) ? hold_reg : word_reg;
  end

  always_ff @(posedge dst_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      pulse_reg <= 1'b0;
      word_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      pulse_reg <= pulse_next;
      word_reg <= word_next;
    end
  end

  assign dst_word_out = word_reg;
  assign dst_pulse_out = pulse_reg;

endmodule
